// ### ppiu_core.sv
// twelve-level priority program interrupt unit with APB status/control
// Behaviour
// - twelve pending bits in three groups of four levels
// - level 1 highest priority, falling with level number
// - group select cumulative: levels 1-4, 1-8 or all twelve
// - inhibit state lets no level interrupt
// - disabled or inhibited pulses stay pending until enabled and permitted
// - current instruction finishes before the interrupt sequence starts
// - taking an interrupt clears the permit state
// - next address saved to 00006; small keeps bits 0-6, big zeroes 0-5
// - accumulator then saved to 00007
// - pc set to 00007, incremented before each level examined
// - first pending enabled level alone cleared, then fetch from pc
// - level n vectors to n-th location from octal 00010
// - group select codes 2500014, 2500015, 2500016 for groups 1-3
// - group select alone never allows interruption
// - permit 2500012 takes effect after the following instruction completes
// - inhibit 2500013 blocks interrupts while pending bits keep accumulating
// - external pins and internal sources each feed a level
// - timer overflow holds its level until branch test or reload clears it
`timescale 1ns/1ps
`include "ppiu_regs.svh"
module ppiu_core #(
   parameter int          ADDR_W   = 15,
   parameter int          TMR_BASE = 8,
   parameter logic        BIG_RST  = 1'b0
) (
   input  wire logic              mclk,
   input  wire logic              nrst,
   input  wire logic [11:0]       irqPin,
   input  wire logic [11:0]       irqInt,
   input  wire logic [3:0]        tmrOvfSet,
   input  wire logic [3:0]        tmrOvfClr,
   input  wire logic              instrDone,
   input  wire logic [19:0]       instrCode,
   input  wire logic [ADDR_W-1:0] pcIn,
   input  wire logic [19:0]       accIn,
   input  wire logic              memAck,
   output logic                   seqBusy,
   output logic                   memWe,
   output logic [ADDR_W-1:0]      memAddr,
   output logic [19:0]            memData,
   output logic [19:0]            memMask,
   output logic                   pcLoad,
   output logic [ADDR_W-1:0]      pcOut,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr
);
   // ********************************************************************
   // state
   // ********************************************************************
   typedef struct packed {
      logic [11:0]          sync1;
      logic [11:0]          sync2;
      logic [11:0]          prev;
      logic [11:0]          pend;
      logic [1:0]           grp;
      logic                 permArm;
      logic                 permOn;
      logic [3:0]           ovf;
      ppiu_pkg::ppiu_state_t st;
      logic [ADDR_W-1:0]    pc;
      logic [3:0]           lvl;
      logic [19:0]          acc;
      logic                 memWe;
      logic [ADDR_W-1:0]    memAddr;
      logic [19:0]          memData;
      logic [19:0]          memMask;
      logic                 pcLoad;
      logic [ADDR_W-1:0]    pcOut;
      logic                 busy;
      logic                 big;
      logic                 pready;
      logic [31:0]          prdata;
      logic                 pslverr;
   } ppiu_core_t;

   ppiu_core_t q;
   ppiu_core_t d;

   function automatic logic [11:0] grpMask(input logic [1:0] g);
      case (g)
         2'h1:    grpMask = 12'h00F;
         2'h2:    grpMask = 12'h0FF;
         2'h3:    grpMask = 12'hFFF;
         default: grpMask = 12'h000;
      endcase
   endfunction

   logic [11:0] srcLvl;
   logic [11:0] rise;
   logic [11:0] enPend;
   logic        isPermit;
   logic        isInhibit;
   logic        permNow;
   logic        take;
   logic        apbAcc;
   logic [3:0]  nextLvl;

   // ********************************************************************
   // next state
   // ********************************************************************
   always_comb begin
      d = q;
      d.sync1 = irqPin;
      d.sync2 = q.sync1;
      srcLvl = q.sync2 | irqInt;
      srcLvl[TMR_BASE +: 4] = srcLvl[TMR_BASE +: 4] | q.ovf;
      d.ovf = (q.ovf & ~tmrOvfClr) | tmrOvfSet;
      d.prev = srcLvl;
      rise = srcLvl & ~q.prev;
      enPend = q.pend & grpMask(q.grp);
      isPermit = instrDone && (instrCode == `PPIU_OP_PERMIT);
      isInhibit = instrDone && (instrCode == `PPIU_OP_INHIBIT);
      // permit active once the next instruction completes
      permNow = !isInhibit && (q.permOn || (q.permArm && instrDone && !isPermit));
      take = (q.st == ppiu_pkg::PPIU_IDLE) && instrDone && permNow && (enPend != 12'h000);
      d.pcLoad = 1'b0;
      nextLvl = q.lvl + 4'h1;
      if (instrDone && q.st == ppiu_pkg::PPIU_IDLE) begin
         case (instrCode)
            `PPIU_OP_SEL_G1: d.grp = 2'h1;
            `PPIU_OP_SEL_G2: d.grp = 2'h2;
            `PPIU_OP_SEL_G3: d.grp = 2'h3;
            default:         d.grp = q.grp;
         endcase
         if (isPermit) begin
            d.permArm = 1'b1;
         end else if (q.permArm) begin
            d.permArm = 1'b0;
            d.permOn  = 1'b1;
         end
         if (instrCode == `PPIU_OP_INHIBIT) begin
            d.permArm = 1'b0;
            d.permOn  = 1'b0;
         end
      end
      case (q.st)
         ppiu_pkg::PPIU_IDLE: begin
            if (take) begin
               d.permArm = 1'b0;
               d.permOn  = 1'b0;
               d.acc     = accIn;
               d.st      = ppiu_pkg::PPIU_SAVEP;
               d.busy    = 1'b1;
               d.memWe   = 1'b1;
               d.memAddr = `PPIU_LOC_PC;
               if (q.big) begin
                  d.memData = 20'(pcIn[`PPIU_ADDR_BIG_W-1:0]);
                  d.memMask = `PPIU_MASK_BIG;
               end else begin
                  d.memData = 20'(pcIn);
                  d.memMask = `PPIU_MASK_SMALL;
               end
            end
         end
         ppiu_pkg::PPIU_SAVEP: begin
            if (memAck) begin
               d.st      = ppiu_pkg::PPIU_SAVEA;
               d.memAddr = `PPIU_LOC_ACC;
               d.memData = q.acc;
               d.memMask = `PPIU_MASK_BIG;
            end
         end
         ppiu_pkg::PPIU_SAVEA: begin
            if (memAck) begin
               // scan starts with pc at 00007
               d.memWe = 1'b0;
               d.st    = ppiu_pkg::PPIU_SCAN;
               d.pc    = `PPIU_LOC_ACC;
               d.lvl   = 4'h0;
            end
         end
         ppiu_pkg::PPIU_SCAN: begin
            d.pc = q.pc + ADDR_W'(1);
            d.lvl = nextLvl;
            // lowest index first is highest priority
            if (enPend[q.lvl] || q.lvl == 4'hB) begin
               // clear only the found level, then fetch
               d.st     = ppiu_pkg::PPIU_IDLE;
               d.busy   = 1'b0;
               d.pcLoad = 1'b1;
               // vector 00010 + n - 1
               d.pcOut  = q.pc + ADDR_W'(1);
            end
         end
         default: begin
            d.st    = ppiu_pkg::PPIU_IDLE;
            d.busy  = 1'b0;
            d.memWe = 1'b0;
         end
      endcase
      // set wins over the scan clear
      d.pend = q.pend;
      if (q.st == ppiu_pkg::PPIU_SCAN && enPend[q.lvl]) begin
         d.pend[q.lvl] = 1'b0;
      end
      d.pend = d.pend | rise;
      // ******************************************************************
      // APB slave, one wait state
      // ******************************************************************
      apbAcc = psel && penable;
      d.pready = apbAcc && !q.pready;
      if (apbAcc && !q.pready) begin
         d.prdata  = 32'h00000000;
         d.pslverr = 1'b0;
         case (paddr)
            `PPIU_OFS_STATUS: begin
               d.prdata[`PPIU_ST_PEND_LSB +: 12] = q.pend;
               d.prdata[`PPIU_ST_GRP_LSB +: 2]   = q.grp;
               d.prdata[`PPIU_ST_ARM_BIT]        = q.permArm;
               d.prdata[`PPIU_ST_PERM_BIT]       = q.permOn;
               d.prdata[`PPIU_ST_BUSY_BIT]       = q.busy;
            end
            `PPIU_OFS_CTRL: d.prdata[`PPIU_CTRL_BIG_BIT] = q.big;
            default:        d.pslverr = 1'b1;
         endcase
      end
      if (apbAcc && q.pready && pwrite && paddr == `PPIU_OFS_CTRL) begin
         d.big = pwdata[`PPIU_CTRL_BIG_BIT];
      end
   end

   // ********************************************************************
   // registers
   // ********************************************************************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         q         <= '0;
         q.st      <= ppiu_pkg::PPIU_IDLE;
         q.big     <= BIG_RST;
      end else begin
         q <= d;
      end
   end

   assign seqBusy = q.busy;
   assign memWe   = q.memWe;
   assign memAddr = q.memAddr;
   assign memData = q.memData;
   assign memMask = q.memMask;
   assign pcLoad  = q.pcLoad;
   assign pcOut   = q.pcOut;
   assign pready  = q.pready;
   assign prdata  = q.prdata;
   assign pslverr = q.pslverr;

   // ********************************************************************
   // assertions
   // ********************************************************************
   a_take_clears_permit: assert property (
      @(posedge mclk) disable iff (!nrst) take |=> !q.permOn && !q.permArm && q.busy)
      else $error("permit survived interrupt take");
   a_pc_save_loc: assert property (
      @(posedge mclk) disable iff (!nrst)
      take |=> memWe && memAddr == `PPIU_LOC_PC && memMask == (q.big ? `PPIU_MASK_BIG
                                                                      : `PPIU_MASK_SMALL))
      else $error("return address save wrong");
   a_acc_save_loc: assert property (
      @(posedge mclk) disable iff (!nrst)
      q.st == ppiu_pkg::PPIU_SAVEP && memAck |=> memAddr == `PPIU_LOC_ACC && memData == q.acc)
      else $error("accumulator save wrong");
   a_vector_addr: assert property (
      @(posedge mclk) disable iff (!nrst)
      q.st == ppiu_pkg::PPIU_SCAN && enPend[q.lvl]
      |=> pcLoad && pcOut == ADDR_W'(8) + ADDR_W'($past(q.lvl)))
      else $error("vector address wrong");
   a_no_take_inhibit: assert property (
      @(posedge mclk) disable iff (!nrst)
      q.st == ppiu_pkg::PPIU_IDLE && !q.permOn && !q.permArm |=> !seqBusy)
      else $error("interrupt taken while inhibited");
   a_inhibit_blocks: assert property (
      @(posedge mclk) disable iff (!nrst)
      q.st == ppiu_pkg::PPIU_IDLE && isInhibit |=> !seqBusy && !q.permOn && !q.permArm)
      else $error("interrupt taken at inhibit");
   a_permit_delay: assert property (
      @(posedge mclk) disable iff (!nrst)
      q.st == ppiu_pkg::PPIU_IDLE && isPermit && !q.permOn |=> !q.permOn)
      else $error("permit effective too early");
   a_pending_kept: assert property (
      @(posedge mclk) disable iff (!nrst)
      q.st != ppiu_pkg::PPIU_SCAN |=> (q.pend & $past(q.pend)) == $past(q.pend))
      else $error("pending bit lost");
   a_edge_sets: assert property (
      @(posedge mclk) disable iff (!nrst) (|rise) |=> (q.pend & $past(rise)) == $past(rise))
      else $error("rising input not captured");
   a_scan_single: assert property (
      @(posedge mclk) disable iff (!nrst)
      q.st == ppiu_pkg::PPIU_SCAN && enPend[q.lvl] && !rise[q.lvl]
      |=> q.pend == (($past(q.pend) & ~(12'h001 << $past(q.lvl))) | $past(rise)))
      else $error("scan cleared wrong bits");
endmodule

// ### ppiu_mem_model.sv
// core memory model that takes the interrupt save writes
`timescale 1ns/1ps
module ppiu_mem_model (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        memWe,
   input  wire logic [14:0] memAddr,
   input  wire logic [19:0] memData,
   input  wire logic [19:0] memMask,
   input  wire logic [2:0]  ackDly,
   output logic             memAck,
   output logic [19:0]      loc6,
   output logic [19:0]      loc7
);
   logic [2:0] waitCnt;
   // ****************************
   // masked write, late or prompt
   // ****************************
   // masked word write
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         memAck  <= 1'b0;
         waitCnt <= 3'h0;
         loc6    <= 20'hFFFFF;
         loc7    <= 20'h00000;
      end else if (memAck || !memWe) begin
         memAck  <= 1'b0;
         waitCnt <= 3'h0;
      end else if (waitCnt == ackDly) begin
         memAck <= 1'b1;
         if (memAddr == 15'h0006) loc6 <= (loc6 & ~memMask) | (memData & memMask);
         if (memAddr == 15'h0007) loc7 <= (loc7 & ~memMask) | (memData & memMask);
      end else begin
         waitCnt <= waitCnt + 3'h1;
      end
   end
endmodule

// ### ppiu_pkg.sv
// types of the priority interrupt unit
package ppiu_pkg;
   typedef enum logic [2:0] {
      PPIU_IDLE  = 3'b000,
      PPIU_SAVEP = 3'b001,
      PPIU_SAVEA = 3'b010,
      PPIU_SCAN  = 3'b011
   } ppiu_state_t;
endpackage

// ### ppiu_regs.svh
// register offsets, reset values, instruction codes and core locations
`ifndef PPIU_REGS_SVH
`define PPIU_REGS_SVH
// ********************************************************************
// APB register map
// ********************************************************************
`define PPIU_OFS_STATUS   8'h00
`define PPIU_OFS_CTRL     8'h04
`define PPIU_RST_CTRL     1'h0
// ********************************************************************
// status field layout
// ********************************************************************
`define PPIU_ST_PEND_LSB  0
`define PPIU_ST_GRP_LSB   12
`define PPIU_ST_ARM_BIT   14
`define PPIU_ST_PERM_BIT  15
`define PPIU_ST_BUSY_BIT  16
`define PPIU_CTRL_BIG_BIT 0
// ********************************************************************
// instruction codes (octal 2500012 .. 2500016)
// ********************************************************************
`define PPIU_OP_PERMIT    20'hA800A
`define PPIU_OP_INHIBIT   20'hA800B
`define PPIU_OP_SEL_G1    20'hA800C
`define PPIU_OP_SEL_G2    20'hA800D
`define PPIU_OP_SEL_G3    20'hA800E
// ********************************************************************
// core locations and save masks
// ********************************************************************
`define PPIU_LOC_PC       15'h0006
`define PPIU_LOC_ACC      15'h0007
`define PPIU_MASK_SMALL   20'h01FFF
`define PPIU_MASK_BIG     20'hFFFFF
`define PPIU_ADDR_BIG_W   14
`endif

// ### testbench.sv
// self-checking bench for the priority interrupt unit
`timescale 1ns/1ps
`include "ppiu_regs.svh"
module testbench;
   logic        mclk, nrst, instrDone, memAck, seqBusy, memWe, pcLoad;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [11:0] irqPin, irqInt;
   logic [3:0]  tmrOvfSet, tmrOvfClr;
   logic [19:0] instrCode, accIn, memData, memMask, loc6, loc7;
   logic [14:0] pcIn, memAddr, pcOut;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0]  ackDly;
   int          mismatches, checksDone, cycles;

   ppiu_core i_ppiu_core (.mclk, .nrst, .irqPin, .irqInt, .tmrOvfSet, .tmrOvfClr,
      .instrDone, .instrCode, .pcIn, .accIn, .memAck, .seqBusy, .memWe, .memAddr,
      .memData, .memMask, .pcLoad, .pcOut, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr);
   ppiu_mem_model i_ppiu_mem_model (.mclk, .nrst, .memWe, .memAddr, .memData,
      .memMask, .ackDly, .memAck, .loc6, .loc7);

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // ****************************
   // shared tasks
   // ****************************
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checksDone++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic ee);
      logic [31:0] d;
      logic        r;
      apb(1'b0, a, 32'h0, d, r);
      chk(d, e);
      chk({31'h0, r}, {31'h0, ee});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] d;
      logic        r;
      apb(1'b1, a, v, d, r);
   endtask
   task automatic instrChk(input logic [19:0] c, input logic busy);
      @(posedge mclk);
      instrDone <= 1'b1;
      instrCode <= c;
      @(posedge mclk);
      instrDone <= 1'b0;
      #1;
      chk({31'h0, seqBusy}, {31'h0, busy});
   endtask
   task automatic waitVec(input logic [14:0] v);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (pcLoad !== 1'b1 && n < 60);
      chk({17'h0, pcOut}, {17'h0, v});
      chk({31'h0, seqBusy}, 32'h0);
   endtask
   // ****************************
   // scenarios
   // ****************************
   task automatic t_reset();
      rdChk(`PPIU_OFS_STATUS, 32'h0, 1'b0);
      rdChk(8'h08, 32'h0, 1'b1);
      wr(`PPIU_OFS_CTRL, 32'h1);
      rdChk(`PPIU_OFS_CTRL, 32'h1, 1'b0);
      wr(`PPIU_OFS_CTRL, 32'h0);
      wr(`PPIU_OFS_STATUS, 32'hFFF);
      rdChk(`PPIU_OFS_STATUS, 32'h0, 1'b0);
   endtask
   task automatic t_permit();
      instrChk(`PPIU_OP_SEL_G1, 1'b0);
      @(posedge mclk);
      irqInt <= 12'h026;
      pcIn   <= 15'h1234;
      accIn  <= 20'hABCDE;
      repeat (2) @(posedge mclk);
      rdChk(`PPIU_OFS_STATUS, 32'h1026, 1'b0);
      instrChk(20'h00000, 1'b0);
      instrChk(`PPIU_OP_PERMIT, 1'b0);
      rdChk(`PPIU_OFS_STATUS, 32'h5026, 1'b0);
      instrChk(20'h00000, 1'b1);
      waitVec(15'h0009);
      chk({12'h0, loc6}, 32'hFF234);
      chk({12'h0, loc7}, 32'hABCDE);
      rdChk(`PPIU_OFS_STATUS, 32'h1024, 1'b0);
      instrChk(20'h00000, 1'b0);
   endtask
   task automatic t_inhibit();
      @(posedge mclk);
      ackDly <= 3'h4;
      instrChk(`PPIU_OP_PERMIT, 1'b0);
      instrChk(`PPIU_OP_INHIBIT, 1'b0);
      instrChk(20'h00000, 1'b0);
      rdChk(`PPIU_OFS_STATUS, 32'h1024, 1'b0);
      instrChk(`PPIU_OP_PERMIT, 1'b0);
      instrChk(20'h00000, 1'b1);
      waitVec(15'h000A);
      instrChk(`PPIU_OP_PERMIT, 1'b0);
      instrChk(20'h00000, 1'b0);
      instrChk(`PPIU_OP_INHIBIT, 1'b0);
      instrChk(`PPIU_OP_SEL_G2, 1'b0);
      instrChk(`PPIU_OP_PERMIT, 1'b0);
      instrChk(20'h00000, 1'b1);
      waitVec(15'h000D);
      rdChk(`PPIU_OFS_STATUS, 32'h2000, 1'b0);
   endtask
   task automatic t_timer();
      @(posedge mclk);
      ackDly    <= 3'h0;
      irqInt    <= 12'h000;
      tmrOvfSet <= 4'h1;
      irqPin    <= 12'h800;
      pcIn      <= 15'h7FFF;
      @(posedge mclk);
      tmrOvfSet <= 4'h0;
      wr(`PPIU_OFS_CTRL, 32'h1);
      instrChk(`PPIU_OP_SEL_G3, 1'b0);
      rdChk(`PPIU_OFS_STATUS, 32'h3900, 1'b0);
      instrChk(`PPIU_OP_PERMIT, 1'b0);
      instrChk(20'h00000, 1'b1);
      waitVec(15'h0010);
      chk({12'h0, loc6}, 32'h03FFF);
      // overflow still held: a second set makes no new edge
      @(posedge mclk);
      tmrOvfSet <= 4'h1;
      @(posedge mclk);
      tmrOvfSet <= 4'h0;
      rdChk(`PPIU_OFS_STATUS, 32'h3800, 1'b0);
      @(posedge mclk);
      tmrOvfClr <= 4'h1;
      @(posedge mclk);
      tmrOvfClr <= 4'h0;
      instrChk(`PPIU_OP_PERMIT, 1'b0);
      instrChk(20'h00000, 1'b1);
      waitVec(15'h0013);
      rdChk(`PPIU_OFS_STATUS, 32'h3000, 1'b0);
      // cleared overflow: the next set is a fresh edge
      @(posedge mclk);
      tmrOvfSet <= 4'h1;
      @(posedge mclk);
      tmrOvfSet <= 4'h0;
      rdChk(`PPIU_OFS_STATUS, 32'h3100, 1'b0);
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         complete_run();
      end
   end
   initial begin
      nrst = 1'b0;
      {psel, penable, pwrite, instrDone} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      {irqPin, irqInt} = 24'h0;
      {tmrOvfSet, tmrOvfClr} = 8'h00;
      instrCode = 20'h00000;
      pcIn = 15'h0000;
      accIn = 20'h00000;
      ackDly = 3'h1;
      mismatches = 0;
      checksDone = 0;
      cycles = 0;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      t_reset();
      t_permit();
      t_inhibit();
      t_timer();
      complete_run();
   end
endmodule
